// file: hdl/power_enable_pkg.sv
// package: register map, field layout and reset values of the power enable bank
package power_enable_pkg;

  // ----------------------------------------------------------------
  // register indices as printed; byte address is index times four
  // ----------------------------------------------------------------
  localparam logic [11:0] IDX_BLOCK_ENABLE_ONE   = 12'h001; // headphone, bias, bandgap
  localparam logic [11:0] IDX_BLOCK_ENABLE_TWO   = 12'h002; // clock out, amps, mic reg
  localparam logic [11:0] IDX_BLOCK_ENABLE_THREE = 12'h003; // dsp paths, digital mic
  localparam logic [11:0] IDX_CORE_REG_CONTROL   = 12'h028; // core regulator control
  localparam logic [11:0] IDX_MIC_REG_CONTROL    = 12'h029; // mic regulator control
  localparam logic [11:0] IDX_PIN_PULL_TWO       = 12'h721; // pin pull control
  localparam logic [11:0] IDX_PIN_STATUS         = 12'h722; // enable pin readback

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_BANDGAP      = 0;
  localparam int BIT_HP_LSB       = 4;   // four headphone stages, bits 7:4
  localparam int BIT_MICB_LSB     = 8;   // two mic bias outputs, bits 9:8
  localparam int BIT_MIC_REG_EN   = 1;
  localparam int BIT_AMP_LSB      = 4;   // right amp bit 4, left amp bit 5
  localparam int BIT_GPCLK        = 11;
  localparam int BIT_DIGMIC_LSB   = 4;   // bits 5:4
  localparam int BIT_PROC_LSB     = 8;   // bits 11:8
  localparam int BIT_DISCH        = 0;
  localparam int BIT_VSEL_LSB     = 1;
  localparam int BIT_BYPASS       = 5;
  localparam int BIT_PIN_PD       = 8;

  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [1:0] CORE_VSEL_RST   = 2'h1;  // 1.0 V
  localparam logic [3:0] MIC_VSEL_RST    = 4'h9;  // 2.6 V
  localparam logic [3:0] MIC_VSEL_MAX    = 4'hB;  // 2.8 V, above is reserved
  localparam logic       DISCH_RST       = 1'b1;
  localparam logic       PIN_PD_RST      = 1'b1;

  // ----------------------------------------------------------------
  // axi response codes
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // control outputs bundled for the analog side
  typedef struct packed {
    logic       bandgap_enable;
    logic [3:0] hp_stage_en;        // {2l,2r,1l,1r}
    logic [1:0] mic_bias_en;        // {two,one}
    logic       gp_clock_out_enable;
    logic [1:0] input_amp_en;       // {left,right}
    logic [3:0] proc_in_en;         // {2l,2r,1l,1r}
    logic [1:0] digmic_two_en;      // {left,right}
  } block_enables_t;

  // regulator controls bundled
  typedef struct packed {
    logic       core_reg_enable;
    logic [1:0] core_reg_voltage_sel;
    logic       core_reg_discharge_sel;
    logic       core_reg_bypass;
    logic       mic_reg_enable;
    logic [3:0] mic_reg_voltage_sel;
    logic       mic_reg_discharge_sel;
    logic       mic_reg_bypass;
    logic       core_reg_pin_pulldown_en;
  } regulator_ctrl_t;

endpackage

// file: hdl/power_enable_register_bank.sv
// power enable register bank with an axi4-lite slave port
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Overview of operation
// R1 - core regulator follows its enable pin
// R2 - pin pulldown switched by pull bit, resets on
// R3 - core voltage select two bits, reset 01
// R4 - core discharge select, resets to one
// R5 - bandgap off puts both regulators in bypass
// R6 - bit 5 reads bypass status, read only
// R7 - mic regulator enable bit, resets off
// R8 - mic voltage four bits, reset 1001
// R9 - mic discharge select floats or discharges
// R10 - software disables externally supplied regulator, floats output
// R11 - bandgap enable bit 0, resets zero
// R12 - software waits 1 ms after bandgap
// R13 - detection stays alive with bandgap off
// R14 - headphone input stage enables, reset zero
// R15 - mic bias enables bits 9 and 8
// R16 - clock out and input amp enables
// R17 - dsp input and digital mic enables
// R18 - software disables unused functions in order
// R19 - status bits ignore writes, read live
// ------------------------------------------------------------------
module power_enable_register_bank (
  // clock and reset
  input  wire logic                                 aclk,
  input  wire logic                                 aresetn,
  // write address channel
  input  wire logic                                 s_axi_awvalid,
  output logic                                      s_axi_awready,
  input  wire logic [15:0]                          s_axi_awaddr,
  // write data channel
  input  wire logic                                 s_axi_wvalid,
  output logic                                      s_axi_wready,
  input  wire logic [31:0]                          s_axi_wdata,
  input  wire logic [3:0]                           s_axi_wstrb,
  // write response channel
  output logic                                      s_axi_bvalid,
  input  wire logic                                 s_axi_bready,
  output logic [1:0]                                s_axi_bresp,
  // read address channel
  input  wire logic                                 s_axi_arvalid,
  output logic                                      s_axi_arready,
  input  wire logic [15:0]                          s_axi_araddr,
  // read data channel
  output logic                                      s_axi_rvalid,
  input  wire logic                                 s_axi_rready,
  output logic [31:0]                               s_axi_rdata,
  output logic [1:0]                                s_axi_rresp,
  // device pin
  input  wire logic                                 core_reg_enable_pin,
  // analog controls
  output power_enable_pkg::block_enables_t          block_enables,
  output power_enable_pkg::regulator_ctrl_t         regulator_ctrl
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------

  // word index from a byte address; two low bits and the top two ignored
  function automatic logic [11:0] word_index(input logic [15:0] addr);
    word_index = addr[13:2];
  endfunction

  // high when the index selects a mapped register
  function automatic logic is_mapped(input logic [11:0] idx);
    is_mapped = (idx == power_enable_pkg::IDX_BLOCK_ENABLE_ONE)
             || (idx == power_enable_pkg::IDX_BLOCK_ENABLE_TWO)
             || (idx == power_enable_pkg::IDX_BLOCK_ENABLE_THREE)
             || (idx == power_enable_pkg::IDX_CORE_REG_CONTROL)
             || (idx == power_enable_pkg::IDX_MIC_REG_CONTROL)
             || (idx == power_enable_pkg::IDX_PIN_PULL_TWO)
             || (idx == power_enable_pkg::IDX_PIN_STATUS);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0] enable_one_ff,   nxt_enable_one;    // block enable one
  logic [15:0] enable_two_ff,   nxt_enable_two;    // block enable two
  logic [15:0] enable_three_ff, nxt_enable_three;  // block enable three
  logic [1:0]  core_vsel_ff,    nxt_core_vsel;     // core voltage code
  logic        core_disch_ff,   nxt_core_disch;    // core discharge select
  logic [3:0]  mic_vsel_ff,     nxt_mic_vsel;      // mic voltage code
  logic        mic_disch_ff,    nxt_mic_disch;     // mic discharge select
  logic        pin_pd_ff,       nxt_pin_pd;        // pin pulldown enable
  logic        pin_ff,          nxt_pin;           // registered enable pin

  logic        aw_held_ff,      nxt_aw_held;       // write address captured
  logic [11:0] aw_idx_ff,       nxt_aw_idx;        // captured write index
  logic        w_held_ff,       nxt_w_held;        // write data captured
  logic [31:0] wdata_ff,        nxt_wdata;         // captured write data
  logic [3:0]  wstrb_ff,        nxt_wstrb;         // captured strobes
  logic        bvalid_ff,       nxt_bvalid;        // write response pending
  logic [1:0]  bresp_ff,        nxt_bresp;         // write response code
  logic        rvalid_ff,       nxt_rvalid;        // read data pending
  logic [31:0] rdata_ff,        nxt_rdata;         // read data
  logic [1:0]  rresp_ff,        nxt_rresp;         // read response code

  power_enable_pkg::block_enables_t  blk_ff,  nxt_blk;  // output copy
  power_enable_pkg::regulator_ctrl_t reg_ff,  nxt_reg;  // output copy

  logic        bypass;          // both regulators bypassed
  logic [15:0] core_rd;         // core regulator readback
  logic [15:0] mic_rd;          // mic regulator readback
  logic        do_write;        // address and data both held
  logic [15:0] wr16;            // low half of write data, strobed

  // ----------------------------------------------------------------
  // regulator status and readback words
  // ----------------------------------------------------------------
  always_comb begin
    // bandgap disabled forces bypass on both regulators
    bypass = ~enable_one_ff[power_enable_pkg::BIT_BANDGAP]; // [R5]
    // status bit is the live mode, never a stored value
    core_rd = 16'h0000;
    core_rd[power_enable_pkg::BIT_BYPASS] = bypass; // [R6] [R19]
    core_rd[power_enable_pkg::BIT_VSEL_LSB +: 2] = core_vsel_ff;
    core_rd[power_enable_pkg::BIT_DISCH] = core_disch_ff;
    mic_rd = 16'h0000;
    mic_rd[power_enable_pkg::BIT_BYPASS] = bypass; // [R6] [R19]
    mic_rd[power_enable_pkg::BIT_VSEL_LSB +: 4] = mic_vsel_ff;
    mic_rd[power_enable_pkg::BIT_DISCH] = mic_disch_ff;
  end

  // ----------------------------------------------------------------
  // axi handshake and register update
  // ----------------------------------------------------------------
  always_comb begin
    // bus state holds by default
    nxt_aw_held = aw_held_ff;
    nxt_aw_idx  = aw_idx_ff;
    nxt_w_held  = w_held_ff;
    nxt_wdata   = wdata_ff;
    nxt_wstrb   = wstrb_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    nxt_rvalid  = rvalid_ff;
    nxt_rdata   = rdata_ff;
    nxt_rresp   = rresp_ff;
    // register file holds by default
    nxt_enable_one   = enable_one_ff;
    nxt_enable_two   = enable_two_ff;
    nxt_enable_three = enable_three_ff;
    nxt_core_vsel    = core_vsel_ff;
    nxt_core_disch   = core_disch_ff;
    nxt_mic_vsel     = mic_vsel_ff;
    nxt_mic_disch    = mic_disch_ff;
    nxt_pin_pd       = pin_pd_ff;
    // first pin sampling stage
    nxt_pin          = core_reg_enable_pin;

    // capture write address and data independently
    if (s_axi_awvalid && !aw_held_ff) begin
      nxt_aw_held = 1'b1;
      nxt_aw_idx  = word_index(s_axi_awaddr);
    end
    if (s_axi_wvalid && !w_held_ff) begin
      nxt_w_held = 1'b1;
      nxt_wdata  = s_axi_wdata;
      nxt_wstrb  = s_axi_wstrb;
    end

    // both held and no response outstanding: perform the write
    do_write = aw_held_ff && w_held_ff && !bvalid_ff;
    wr16 = 16'h0000;
    if (do_write) begin
      nxt_aw_held = 1'b0;
      nxt_w_held  = 1'b0;
      nxt_bvalid  = 1'b1;
      nxt_bresp   = is_mapped(aw_idx_ff) ? power_enable_pkg::RESP_OKAY
                                         : power_enable_pkg::RESP_SLVERR;
      // only writable fields change
      case (aw_idx_ff)
        power_enable_pkg::IDX_BLOCK_ENABLE_ONE: begin
          wr16 = enable_one_ff;
          if (wstrb_ff[0]) begin
            // bandgap and headphone stages in the low byte
            wr16[power_enable_pkg::BIT_BANDGAP] = wdata_ff[0]; // [R11]
            wr16[power_enable_pkg::BIT_HP_LSB +: 4] = wdata_ff[7:4]; // [R14]
          end
          if (wstrb_ff[1]) begin
            wr16[power_enable_pkg::BIT_MICB_LSB +: 2] = wdata_ff[9:8]; // [R15]
          end
          nxt_enable_one = wr16;
        end
        power_enable_pkg::IDX_BLOCK_ENABLE_TWO: begin
          wr16 = enable_two_ff;
          if (wstrb_ff[0]) begin
            wr16[power_enable_pkg::BIT_MIC_REG_EN] = wdata_ff[1]; // [R7]
            wr16[power_enable_pkg::BIT_AMP_LSB +: 2] = wdata_ff[5:4]; // [R16]
          end
          if (wstrb_ff[1]) begin
            wr16[power_enable_pkg::BIT_GPCLK] = wdata_ff[11]; // [R16]
          end
          nxt_enable_two = wr16;
        end
        power_enable_pkg::IDX_BLOCK_ENABLE_THREE: begin
          wr16 = enable_three_ff;
          if (wstrb_ff[0]) begin
            wr16[power_enable_pkg::BIT_DIGMIC_LSB +: 2] = wdata_ff[5:4]; // [R17]
          end
          if (wstrb_ff[1]) begin
            wr16[power_enable_pkg::BIT_PROC_LSB +: 4] = wdata_ff[11:8]; // [R17]
          end
          nxt_enable_three = wr16;
        end
        power_enable_pkg::IDX_CORE_REG_CONTROL: begin
          // bypass status bit is not writable
          if (wstrb_ff[0]) begin
            nxt_core_vsel  = wdata_ff[2:1]; // [R3]
            nxt_core_disch = wdata_ff[0]; // [R4]
          end
        end
        power_enable_pkg::IDX_MIC_REG_CONTROL: begin
          // reserved voltage codes are stored as written
          if (wstrb_ff[0]) begin
            nxt_mic_vsel  = wdata_ff[4:1]; // [R8]
            nxt_mic_disch = wdata_ff[0]; // [R9]
          end
        end
        power_enable_pkg::IDX_PIN_PULL_TWO: begin
          if (wstrb_ff[1]) begin
            nxt_pin_pd = wdata_ff[8]; // [R2]
          end
        end
        default: begin
          // unmapped or read-only: no state change
        end
      endcase
    end

    // write response retires on bready
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end

    // read: accept when no data outstanding
    if (s_axi_arvalid && !rvalid_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = power_enable_pkg::RESP_OKAY;
      nxt_rdata  = 32'h0000_0000;
      // unused bits read as zero
      case (word_index(s_axi_araddr))
        power_enable_pkg::IDX_BLOCK_ENABLE_ONE:   nxt_rdata[15:0] = enable_one_ff;
        power_enable_pkg::IDX_BLOCK_ENABLE_TWO:   nxt_rdata[15:0] = enable_two_ff;
        power_enable_pkg::IDX_BLOCK_ENABLE_THREE: nxt_rdata[15:0] = enable_three_ff;
        power_enable_pkg::IDX_CORE_REG_CONTROL:   nxt_rdata[15:0] = core_rd;
        power_enable_pkg::IDX_MIC_REG_CONTROL:    nxt_rdata[15:0] = mic_rd;
        power_enable_pkg::IDX_PIN_PULL_TWO:
          nxt_rdata[power_enable_pkg::BIT_PIN_PD] = pin_pd_ff;
        power_enable_pkg::IDX_PIN_STATUS:         nxt_rdata[0] = pin_ff;
        default: begin
          nxt_rresp = power_enable_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // output bundles
  // ----------------------------------------------------------------
  always_comb begin
    // outputs take the next values, except core_reg_enable, which takes pin_ff
    nxt_blk.bandgap_enable      = nxt_enable_one[power_enable_pkg::BIT_BANDGAP]; // [R11]
    nxt_blk.hp_stage_en         = nxt_enable_one[power_enable_pkg::BIT_HP_LSB +: 4]; // [R14]
    nxt_blk.mic_bias_en         = nxt_enable_one[power_enable_pkg::BIT_MICB_LSB +: 2]; // [R15]
    nxt_blk.gp_clock_out_enable = nxt_enable_two[power_enable_pkg::BIT_GPCLK]; // [R16]
    nxt_blk.input_amp_en        = nxt_enable_two[power_enable_pkg::BIT_AMP_LSB +: 2]; // [R16]
    nxt_blk.proc_in_en          = nxt_enable_three[power_enable_pkg::BIT_PROC_LSB +: 4]; // [R17]
    nxt_blk.digmic_two_en       = nxt_enable_three[power_enable_pkg::BIT_DIGMIC_LSB +: 2]; // [R17]
    // core regulator follows the pin, two sampling stages
    nxt_reg.core_reg_enable        = pin_ff; // [R1]
    nxt_reg.core_reg_voltage_sel   = nxt_core_vsel;
    nxt_reg.core_reg_discharge_sel = nxt_core_disch;
    nxt_reg.core_reg_bypass        = ~nxt_enable_one[power_enable_pkg::BIT_BANDGAP]; // [R5]
    // mic enable ignores the bandgap
    nxt_reg.mic_reg_enable         = nxt_enable_two[power_enable_pkg::BIT_MIC_REG_EN]; // [R7][R13]
    nxt_reg.mic_reg_voltage_sel    = nxt_mic_vsel;
    nxt_reg.mic_reg_discharge_sel  = nxt_mic_disch; // [R9]
    nxt_reg.mic_reg_bypass         = ~nxt_enable_one[power_enable_pkg::BIT_BANDGAP]; // [R5]
    nxt_reg.core_reg_pin_pulldown_en = nxt_pin_pd; // [R2]
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    // synchronous reset to defaults
    if (!aresetn) begin
      enable_one_ff   <= 16'h0000;
      enable_two_ff   <= 16'h0000;
      enable_three_ff <= 16'h0000;
      core_vsel_ff    <= power_enable_pkg::CORE_VSEL_RST;
      core_disch_ff   <= power_enable_pkg::DISCH_RST;
      mic_vsel_ff     <= power_enable_pkg::MIC_VSEL_RST;
      mic_disch_ff    <= power_enable_pkg::DISCH_RST;
      pin_pd_ff       <= power_enable_pkg::PIN_PD_RST;
      pin_ff          <= 1'b0;
      // bus side idle
      aw_held_ff      <= 1'b0;
      aw_idx_ff       <= 12'h000;
      w_held_ff       <= 1'b0;
      wdata_ff        <= 32'h0000_0000;
      wstrb_ff        <= 4'h0;
      bvalid_ff       <= 1'b0;
      bresp_ff        <= 2'h0;
      rvalid_ff       <= 1'b0;
      rdata_ff        <= 32'h0000_0000;
      rresp_ff        <= 2'h0;

      blk_ff          <= '0;
      // reset image of the regulator outputs; bypass set as bandgap is off
      reg_ff          <= '{core_reg_enable: 1'b0,
                           core_reg_voltage_sel: power_enable_pkg::CORE_VSEL_RST,
                           core_reg_discharge_sel: power_enable_pkg::DISCH_RST,
                           core_reg_bypass: 1'b1,
                           mic_reg_enable: 1'b0,
                           mic_reg_voltage_sel: power_enable_pkg::MIC_VSEL_RST,
                           mic_reg_discharge_sel: power_enable_pkg::DISCH_RST,
                           mic_reg_bypass: 1'b1,
                           core_reg_pin_pulldown_en: power_enable_pkg::PIN_PD_RST};
    end else begin
      enable_one_ff   <= nxt_enable_one;
      enable_two_ff   <= nxt_enable_two;
      enable_three_ff <= nxt_enable_three;
      core_vsel_ff    <= nxt_core_vsel;
      core_disch_ff   <= nxt_core_disch;
      mic_vsel_ff     <= nxt_mic_vsel;
      mic_disch_ff    <= nxt_mic_disch;
      pin_pd_ff       <= nxt_pin_pd;
      pin_ff          <= nxt_pin;

      aw_held_ff      <= nxt_aw_held;
      aw_idx_ff       <= nxt_aw_idx;
      w_held_ff       <= nxt_w_held;
      wdata_ff        <= nxt_wdata;
      wstrb_ff        <= nxt_wstrb;
      bvalid_ff       <= nxt_bvalid;
      bresp_ff        <= nxt_bresp;
      rvalid_ff       <= nxt_rvalid;
      rdata_ff        <= nxt_rdata;
      rresp_ff        <= nxt_rresp;

      blk_ff          <= nxt_blk;
      reg_ff          <= nxt_reg;
    end
  end

  // ----------------------------------------------------------------
  // port drive
  // ----------------------------------------------------------------
  // ready is high while the capture slot is empty
  assign s_axi_awready  = ~aw_held_ff;
  assign s_axi_wready   = ~w_held_ff;
  // answers straight from flops
  assign s_axi_bvalid   = bvalid_ff;
  assign s_axi_bresp    = bresp_ff;
  assign s_axi_arready  = ~rvalid_ff;
  assign s_axi_rvalid   = rvalid_ff;
  assign s_axi_rdata    = rdata_ff;
  assign s_axi_rresp    = rresp_ff;

  assign block_enables  = blk_ff;
  assign regulator_ctrl = reg_ff;

endmodule

// file: tb/power_enable_asserts.sv
// port-level checks for the power enable register bank
`timescale 1ns/1ps
module power_enable_asserts (
  // clock and reset
  input wire logic                              aclk,
  input wire logic                              aresetn,
  // write channels
  input wire logic                              s_axi_awvalid,
  input wire logic                              s_axi_awready,
  input wire logic [15:0]                       s_axi_awaddr,
  input wire logic                              s_axi_wvalid,
  input wire logic                              s_axi_wready,
  input wire logic [31:0]                       s_axi_wdata,
  input wire logic [3:0]                        s_axi_wstrb,
  input wire logic                              s_axi_bvalid,
  input wire logic                              s_axi_bready,
  input wire logic [1:0]                        s_axi_bresp,
  // read channels
  input wire logic                              s_axi_arvalid,
  input wire logic                              s_axi_arready,
  input wire logic [15:0]                       s_axi_araddr,
  input wire logic                              s_axi_rvalid,
  input wire logic                              s_axi_rready,
  input wire logic [31:0]                       s_axi_rdata,
  input wire logic [1:0]                        s_axi_rresp,
  // pin and analog controls
  input wire logic                              core_reg_enable_pin,
  input wire power_enable_pkg::block_enables_t  block_enables,
  input wire power_enable_pkg::regulator_ctrl_t regulator_ctrl
);
  // ----------------------------------------------------------------
  // one clock domain, reset disables all checks
  // ----------------------------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_core_bypass: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr[13:2] == power_enable_pkg::IDX_CORE_REG_CONTROL
    |=> s_axi_rdata[5] == $past(regulator_ctrl.core_reg_bypass)) else $error("core bypass");
  chk_mic_bypass: assert property (
    $stable(block_enables.bandgap_enable) |->
    regulator_ctrl.mic_reg_bypass == !block_enables.bandgap_enable) else $error("mic bypass");
  chk_pin_follow: assert property (
    $past(aresetn) && $past(aresetn, 2) |->
    regulator_ctrl.core_reg_enable == $past(core_reg_enable_pin, 2)) else $error("pin follow");
  chk_reset_values: assert property (
    $rose(aresetn) |-> 32'(regulator_ctrl) == 32'h074F && block_enables == 16'h0000)
    else $error("reset values");
  chk_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  chk_addr_busy: assert property (
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready) else $error("awready stayed high");
  chk_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready) else $error("read late");
  chk_rdata_top: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000) else $error("upper read bits set");
  chk_enables_quiet: assert property (
    !$stable(block_enables) |-> s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("enables moved without write");
endmodule

// file: tb/tb.sv
// self-checking bench for the power enable register bank
`timescale 1ns/1ps
module tb;
  // ----------------------------------------------------------------
  // bus drivers, design outputs, counters
  // ----------------------------------------------------------------
  logic                              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, pin;
  logic [15:0]                       awaddr, araddr;
  logic [31:0]                       wdata, rd, rdata;
  logic [3:0]                        wstrb;
  logic [1:0]                        rsp, bresp, rresp;
  logic                              awready, wready, bvalid, arready, rvalid;
  int                                err_count, comparisons;
  power_enable_pkg::block_enables_t  en;
  power_enable_pkg::regulator_ctrl_t ctl;
  // row: write flag, byte address, data, expected readback, expected response
  typedef struct packed {logic w; logic [15:0] a, d, x; logic [1:0] r;} row_t;
  row_t rows [16] = '{
    {1'h0, 16'h0004, 16'h0000, 16'h0000, 2'h0}, {1'h0, 16'h0008, 16'h0000, 16'h0000, 2'h0},
    {1'h0, 16'h000C, 16'h0000, 16'h0000, 2'h0}, {1'h0, 16'h00A0, 16'h0000, 16'h0023, 2'h0},
    {1'h0, 16'h00A4, 16'h0000, 16'h0033, 2'h0}, {1'h0, 16'h1C84, 16'h0000, 16'h0100, 2'h0},
    {1'h1, 16'h0004, 16'hFFFF, 16'h03F1, 2'h0}, {1'h1, 16'h0008, 16'hFFFF, 16'h0832, 2'h0},
    {1'h1, 16'h000C, 16'hFFFF, 16'h0F30, 2'h0}, {1'h1, 16'h00A0, 16'hFFFF, 16'h0007, 2'h0},
    {1'h1, 16'h00A4, 16'hFFFF, 16'h001F, 2'h0}, {1'h1, 16'h1C84, 16'h0000, 16'h0000, 2'h0},
    {1'h1, 16'h0004, 16'h0000, 16'h0000, 2'h0}, {1'h1, 16'h00A0, 16'h0002, 16'h0022, 2'h0},
    {1'h1, 16'h00A4, 16'h0018, 16'h0038, 2'h0}, {1'h1, 16'h0040, 16'hFFFF, 16'h0000, 2'h2}};

  power_enable_register_bank power_enable_register_bank_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .core_reg_enable_pin(pin), .block_enables(en), .regulator_ctrl(ctl));

  // ----------------------------------------------------------------
  // bus tasks, compares, verdict
  // ----------------------------------------------------------------
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge aclk); while (bvalid !== 1'b1);
    rsp = bresp;
  endtask
  task automatic rd_reg(input logic [15:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
  endtask
  task automatic cmpw(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t word %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmpr(input logic [1:0] g, input logic [1:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t response %h expected %h", $time, g, e);
    end
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // clock, 20 ns period
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // watchdog, some 10000 cycles beyond the expected run
  initial begin
    repeat (60000) @(posedge aclk);
    err_count++;
    print_verdict();
  end
  // main sequence
  initial begin
    {aresetn, awvalid, wvalid, arvalid, pin, awaddr, araddr, wdata, wstrb} = '0;
    {bready, rready} = 2'b11;
    err_count = 0;
    comparisons = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, {16'h0000, rows[i].d}, 4'hF);
      if (rows[i].w && rows[i].d[0] && rows[i].a == 16'h0004)
        repeat (50000) @(posedge aclk);
      if (rows[i].w) cmpr(rsp, rows[i].r);
      rd_reg(rows[i].a);
      cmpr(rsp, rows[i].r);
      if (rows[i].r === power_enable_pkg::RESP_OKAY) cmpw(rd, {16'h0000, rows[i].x});
    end
    cmpw(32'(ctl.mic_reg_enable), 32'h00000001);
    $display("table done");
    wr(16'h0004, 32'h0000FFFF, 4'h1);
    rd_reg(16'h0004);
    cmpw(rd, 32'h000000F1);
    wr(16'h0004, 32'h000003F1, 4'h3);
    repeat (3) @(posedge aclk);
    cmpw(32'(en), 32'h0000FFFF);
    cmpw(32'(ctl), 32'h000004E0);
    $display("ports done");
    pin <= 1'b1;
    repeat (3) @(posedge aclk);
    cmpw(32'(ctl.core_reg_enable), 32'h00000001);
    rd_reg(16'h1C88);
    cmpw(rd, 32'h00000001);
    pin <= 1'b0;
    $display("pin done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    cmpw(32'(ctl), 32'h0000074F);
    cmpw(32'(en), 32'h00000000);
    $display("second reset done");
    print_verdict();
  end
endmodule

bind power_enable_register_bank power_enable_asserts power_enable_asserts_inst (.*);
